// File: rtl/sadc_pkg.sv
// Shared constants and types for the converter sequencer block.
package sadc_pkg;
  // Register byte offsets.
  localparam logic [7:0] SADC_CTRL_OFS = 8'h00;
  localparam logic [7:0] SADC_CLK_OFS = 8'h04;
  localparam logic [7:0] SADC_SAMP_OFS = 8'h08;
  localparam logic [7:0] SADC_DELAY_OFS = 8'h0C;
  localparam logic [7:0] SADC_THR_OFS = 8'h10;
  localparam logic [7:0] SADC_INTFL_OFS = 8'h14;
  localparam logic [7:0] SADC_INTEN_OFS = 8'h18;
  localparam logic [7:0] SADC_FIFO_OFS = 8'h1C;
  localparam logic [7:0] SADC_STAT_OFS = 8'h20;
  localparam logic [7:0] SADC_DIVSEL_OFS = 8'h24;
  localparam logic [7:0] SADC_DIVCFG_OFS = 8'h28;
  localparam logic [7:0] SADC_CHSEL_OFS = 8'h40;
  localparam logic [7:0] SADC_CHSEL_END = 8'h5C;
  // Control register fields.
  localparam int SADC_CTRL_RESETN = 0;
  localparam int SADC_CTRL_BIAS = 1;
  localparam int SADC_CTRL_EN = 2;
  localparam int SADC_CTRL_START = 3;
  localparam int SADC_CTRL_CONT = 4;
  localparam int SADC_CTRL_TRIG = 5;
  localparam int SADC_CTRL_STOP = 7;
  localparam int SADC_CTRL_SLOTS = 8;
  // Sample timing and divider-config fields.
  localparam int SADC_SAMP_IDLE = 16;
  localparam int SADC_DIVCFG_LPS = 16;
  localparam int SADC_DIVCFG_LPL = 17;
  localparam int SADC_CLK_DIV = 4;
  // Interrupt bits.
  localparam int SADC_INT_THR = 0;
  localparam int SADC_INT_OVR = 1;
  localparam int SADC_INT_DONE = 2;
  localparam int SADC_INT_RDY = 3;
  localparam int SADC_INT_W = 4;
  // Trigger selections.
  localparam logic [1:0] SADC_TRIG_SW = 2'h0;
  localparam logic [1:0] SADC_TRIG_TMR = 2'h1;
  localparam logic [1:0] SADC_TRIG_RISE = 2'h2;
  // Timing bases in conversion clock cycles.
  localparam logic [15:0] SADC_TRACK_BASE = 16'h0004;
  localparam logic [15:0] SADC_HOLD_BASE = 16'h0011;
  // Reset values.
  localparam logic [7:0] SADC_TRACK_RST = 8'h04;
  localparam logic [5:0] SADC_SLOTS_RST = 6'h00;
  // Channel identifiers and slot limits.
  localparam logic [4:0] SADC_GROUND_ID = 5'h10;
  localparam logic [5:0] SADC_LAST_SLOT = 6'h1F;
  localparam int SADC_NSLOT = 32;
  localparam int SADC_NDIV = 13;
  localparam int SADC_LP_LAST = 11;
  // Result FIFO geometry.
  localparam int SADC_FIFO_AW = 4;
  localparam int SADC_FIFO_DEPTH = 16;
  // Clock source selections.
  localparam logic [1:0] SADC_SRC_SYS = 2'h0;
  localparam logic [1:0] SADC_SRC_EXT = 2'h1;
  localparam logic [1:0] SADC_SRC_BAUD = 2'h2;
  localparam logic [2:0] SADC_DIV_MAX = 3'h3;
  // Sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE, ST_ARMED, ST_TRACK, ST_HOLD, ST_DELAY
  } sadc_state_type;
endpackage : sadc_pkg

// File: rtl/sadc_clkgen.sv
// Conversion clock tick generator: source select and power-of-two divider.
`timescale 1ns/1ns
module sadc_clkgen (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [1:0] src_sel,
  input wire logic [2:0] div_sel,
  input wire logic ext_clk_pin,
  input wire logic baud_osc,
  input wire logic fast_osc,
  output logic conv_tick
);
  import sadc_pkg::*;
  logic [2:0] sync1_ff; // First synchroniser stage, read only by stage two.
  logic [2:0] sync2_ff; // Second synchroniser stage.
  logic [2:0] prev_ff; // Delayed copy for rising edge detection.
  logic [3:0] cnt_ff; // Source edge counter.
  logic src_edge; // One source clock edge seen this cycle.
  logic [3:0] top; // Last count of one divided period.

  // Slow sources are sampled; they must run below half the system clock.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
      prev_ff <= 3'h0;
    end else begin
      sync1_ff <= {fast_osc, baud_osc, ext_clk_pin};
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
    end
  end

  // Choose the source edge.
  always_comb begin
    unique case (src_sel)
      SADC_SRC_SYS: src_edge = 1'b1;
      SADC_SRC_EXT: src_edge = sync2_ff[0] & ~prev_ff[0];
      SADC_SRC_BAUD: src_edge = sync2_ff[1] & ~prev_ff[1];
      default: src_edge = sync2_ff[2] & ~prev_ff[2];
    endcase
    top = 4'((4'h2 << div_sel[1:0]) - 4'h1);
  end

  // Divide by two to the power of setting plus one, or pass through.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= 4'h0;
      conv_tick <= 1'b0;
    end else if (!src_edge) begin
      conv_tick <= 1'b0;
    end else if (div_sel > SADC_DIV_MAX || cnt_ff >= top) begin
      cnt_ff <= 4'h0;
      conv_tick <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 4'h1;
      conv_tick <= 1'b0;
    end
  end

  property p_undivided;
    @(posedge clk) disable iff (!rstn)
    (src_sel == SADC_SRC_SYS && div_sel > SADC_DIV_MAX) [*2] |-> conv_tick;
  endproperty
  a_undivided: assert property (p_undivided) else $error("undivided tick missing");
endmodule : sadc_clkgen

// File: rtl/sadc_seq.sv
// Converter sequencer: registers, slot sequencing, sample timing, result FIFO.
//
// Notes on behaviour
// - Sequence runs once or continuously.
// - Start by software or hardware event.
// - Programmable delay between continuous sequences.
// - Slots from zero upward to configured last.
// - Each slot holds its own channel identifier.
// - Every result goes into the result FIFO.
// - FIFO level threshold raises an interrupt.
// - Identifiers 0-16 valid, 17-31 reserved.
// - Two-bit select picks converter source clock.
// - Divide by power of two, else undivided.
// - Sample clock high track, low hold.
// - Track is four plus count, hold seventeen plus.
// - Per-channel divider select and dynamic enable.
// - Low-power bits drop dividers, channels 0-11.
// - Converter reset, sleep, nap and on modes.
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ns
module sadc_seq (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic irq,
  input wire logic ext_clk_pin,
  input wire logic baud_osc,
  input wire logic fast_osc,
  input wire logic timer_evt,
  input wire logic trig_pin,
  input wire logic lowpower_mode,
  input wire logic [11:0] core_data,
  output logic sample_clk,
  output logic [4:0] channel_sel,
  output logic core_resetn,
  output logic core_bias_en,
  output logic core_enable,
  output logic [25:0] input_divider_select,
  output logic [12:0] divider_enable
);
  import sadc_pkg::*;

  // Reserved identifiers measure ground instead.
  function automatic logic [4:0] map_chan(input logic [4:0] id);
    map_chan = (id > SADC_GROUND_ID) ? SADC_GROUND_ID : id;
  endfunction : map_chan

  // Pointer step with natural wrap.
  function automatic logic [SADC_FIFO_AW-1:0] ptr_inc(input logic [SADC_FIFO_AW-1:0] p);
    ptr_inc = p + 1'b1;
  endfunction : ptr_inc

  // Configuration registers.
  logic [31:0] ctrl_ff; // Sequencer control; start and stop are not stored.
  logic [6:0] clkcfg_ff; // Source select and divider setting.
  logic [7:0] track_cnt_ff; // Extra track cycles.
  logic [7:0] idle_cnt_ff; // Extra hold cycles.
  logic [15:0] delay_ff; // Gap between continuous sequences.
  logic [SADC_FIFO_AW:0] thr_ff; // FIFO level threshold.
  logic [SADC_INT_W-1:0] intfl_ff; // Sticky interrupt flags.
  logic [SADC_INT_W-1:0] inten_ff; // Interrupt mask.
  logic [25:0] divsel_ff; // Two bits per divided channel.
  logic [17:0] divcfg_ff; // Dynamic enables and low-power disables.
  logic [4:0] slot_chan [SADC_NSLOT]; // Channel selection bank.

  // Sequencer state.
  sadc_state_type state_ff, nxt_state;
  logic [4:0] slot_ff, nxt_slot; // Current slot.
  logic [15:0] cnt_ff, nxt_cnt; // Phase cycle counter.
  logic trig_hit_ff; // Trigger seen, waiting for a period start.
  logic go_ff; // Start request pending.
  logic [2:0] pin_ff; // Trigger pin synchroniser and edge history.
  logic conv_tick; // Conversion clock tick.
  logic ready; // Converter powered on.
  logic ready_d_ff; // Previous ready, for the ready event.

  // Result FIFO.
  logic [16:0] fifo_mem [SADC_FIFO_DEPTH]; // Channel and data words.
  logic [SADC_FIFO_AW-1:0] wp_ff, rp_ff; // Write and read pointers.
  logic [SADC_FIFO_AW:0] level_ff; // Words held.
  logic push, pop, full, empty, done_evt;

  wire wr_ctrl = wr && addr == SADC_CTRL_OFS;
  wire [5:0] slots_cfg = ctrl_ff[SADC_CTRL_SLOTS +: 6];
  // Lengths above the last slot saturate at slot 31.
  wire [4:0] last_slot = (slots_cfg > SADC_LAST_SLOT) ? 5'h1F : slots_cfg[4:0];
  wire [15:0] track_len = SADC_TRACK_BASE + {8'h00, track_cnt_ff};
  wire [15:0] hold_len = SADC_HOLD_BASE + {8'h00, idle_cnt_ff};
  wire cont = ctrl_ff[SADC_CTRL_CONT];
  wire [1:0] trig_sel = ctrl_ff[SADC_CTRL_TRIG +: 2];

  sadc_clkgen u_clkgen (
    .clk(clk),
    .rstn(rstn),
    .src_sel(clkcfg_ff[1:0]),
    .div_sel(clkcfg_ff[SADC_CLK_DIV +: 3]),
    .ext_clk_pin(ext_clk_pin),
    .baud_osc(baud_osc),
    .fast_osc(fast_osc),
    .conv_tick(conv_tick)
  );

  // Converter mode follows the three power bits.
  assign ready = ctrl_ff[SADC_CTRL_RESETN] & ctrl_ff[SADC_CTRL_BIAS] & ctrl_ff[SADC_CTRL_EN];
  assign full = level_ff[SADC_FIFO_AW];
  assign empty = level_ff == '0;
  assign pop = rd && addr == SADC_FIFO_OFS && !empty;

  // Software register writes.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_ff <= 32'h0;
      clkcfg_ff <= 7'h0;
      track_cnt_ff <= SADC_TRACK_RST;
      idle_cnt_ff <= 8'h0;
      delay_ff <= 16'h0;
      thr_ff <= '0;
      inten_ff <= '0;
      divsel_ff <= 26'h0;
      divcfg_ff <= 18'h0;
    end else if (wr) begin
      unique case (addr)
        SADC_CTRL_OFS: ctrl_ff <= {18'h0, wdata[13:8], 1'b0, wdata[6:4], 1'b0, wdata[2:0]};
        SADC_CLK_OFS: clkcfg_ff <= {wdata[6:4], 2'h0, wdata[1:0]};
        SADC_SAMP_OFS: begin
          track_cnt_ff <= wdata[7:0];
          idle_cnt_ff <= wdata[SADC_SAMP_IDLE +: 8];
        end
        SADC_DELAY_OFS: delay_ff <= wdata[15:0];
        SADC_THR_OFS: thr_ff <= wdata[SADC_FIFO_AW:0];
        SADC_INTEN_OFS: inten_ff <= wdata[SADC_INT_W-1:0];
        SADC_DIVSEL_OFS: divsel_ff <= wdata[25:0];
        SADC_DIVCFG_OFS: divcfg_ff <= wdata[17:0];
        default: ;
      endcase
    end
  end

  // Channel selection bank, four slots per word.
  always_ff @(posedge clk) begin
    if (wr && addr >= SADC_CHSEL_OFS && addr <= SADC_CHSEL_END) begin
      for (int i = 0; i < 4; i++) begin
        slot_chan[{addr[4:2], 2'(i)}] <= wdata[8*i +: 5];
      end
    end
  end

  // Start request and trigger capture.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_ff <= 3'h0;
      go_ff <= 1'b0;
      trig_hit_ff <= 1'b0;
    end else begin
      pin_ff <= {pin_ff[1:0], trig_pin};
      go_ff <= wr_ctrl && wdata[SADC_CTRL_START];
      if (state_ff != ST_ARMED) begin
        trig_hit_ff <= 1'b0;
      end else if (trig_sel == SADC_TRIG_SW) begin
        trig_hit_ff <= 1'b1;
      end else if (trig_sel == SADC_TRIG_TMR) begin
        trig_hit_ff <= trig_hit_ff | timer_evt;
      end else if (trig_sel == SADC_TRIG_RISE) begin
        trig_hit_ff <= trig_hit_ff | (pin_ff[1] & ~pin_ff[2]);
      end else begin
        trig_hit_ff <= trig_hit_ff | (~pin_ff[1] & pin_ff[2]);
      end
    end
  end

  // Sequencer next state.
  always_comb begin
    nxt_state = state_ff;
    nxt_slot = slot_ff;
    nxt_cnt = cnt_ff;
    push = 1'b0;
    done_evt = 1'b0;
    if (!ready || (wr_ctrl && wdata[SADC_CTRL_STOP])) begin
      nxt_state = ST_IDLE;
    end else begin
      unique case (state_ff)
        ST_IDLE: if (go_ff) begin
          nxt_state = ST_ARMED;
        end
        ST_ARMED: if (trig_hit_ff && conv_tick) begin
          nxt_state = ST_TRACK;
          nxt_slot = 5'h0;
          nxt_cnt = 16'h0;
        end
        ST_TRACK: if (conv_tick) begin
          nxt_cnt = cnt_ff + 16'h1;
          if (nxt_cnt >= track_len) begin
            nxt_state = ST_HOLD;
            nxt_cnt = 16'h0;
          end
        end
        ST_HOLD: if (conv_tick) begin
          nxt_cnt = cnt_ff + 16'h1;
          if (nxt_cnt >= hold_len) begin
            push = 1'b1;
            nxt_cnt = 16'h0;
            if (slot_ff < last_slot) begin
              nxt_slot = slot_ff + 5'h1;
              nxt_state = ST_TRACK;
            end else begin
              done_evt = 1'b1;
              nxt_slot = 5'h0;
              if (!cont) begin
                nxt_state = ST_IDLE;
              end else if (delay_ff == 16'h0) begin
                nxt_state = ST_TRACK;
              end else begin
                nxt_state = ST_DELAY;
              end
            end
          end
        end
        ST_DELAY: if (conv_tick) begin
          nxt_cnt = cnt_ff + 16'h1;
          if (nxt_cnt >= delay_ff) begin
            nxt_state = ST_TRACK;
            nxt_cnt = 16'h0;
          end
        end
        default: nxt_state = ST_IDLE;
      endcase
    end
  end

  // Sequencer registers and core-facing outputs.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= ST_IDLE;
      slot_ff <= 5'h0;
      cnt_ff <= 16'h0;
      sample_clk <= 1'b0;
      channel_sel <= SADC_GROUND_ID;
    end else begin
      state_ff <= nxt_state;
      slot_ff <= nxt_slot;
      cnt_ff <= nxt_cnt;
      sample_clk <= nxt_state == ST_TRACK;
      // Load only while a sequence runs. The bank is not reset, so loading while idle
      // would put an unknown on the multiplexer select.
      if (nxt_state inside {ST_TRACK, ST_HOLD, ST_DELAY}) begin
        channel_sel <= map_chan(slot_chan[nxt_slot]);
      end
    end
  end

  // Converter power controls.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      core_resetn <= 1'b0;
      core_bias_en <= 1'b0;
      core_enable <= 1'b0;
    end else begin
      core_resetn <= ctrl_ff[SADC_CTRL_RESETN];
      core_bias_en <= ctrl_ff[SADC_CTRL_RESETN] & ctrl_ff[SADC_CTRL_BIAS];
      core_enable <= ready;
    end
  end

  // Input divider control per channel.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      input_divider_select <= 26'h0;
      divider_enable <= 13'h0;
    end else begin
      input_divider_select <= divsel_ff;
      for (int n = 0; n < SADC_NDIV; n++) begin
        logic [1:0] sel;
        logic meas;
        logic lp_off;
        sel = divsel_ff[2*n +: 2];
        meas = state_ff != ST_IDLE && state_ff != ST_ARMED && channel_sel == 5'(n);
        if (n > SADC_LP_LAST) begin
          lp_off = lowpower_mode;
        end else begin
          lp_off = lowpower_mode && ((sel == 2'h1 && divcfg_ff[SADC_DIVCFG_LPS])
                   || (sel == 2'h2 && divcfg_ff[SADC_DIVCFG_LPL]));
        end
        divider_enable[n] <= sel != 2'h0 && (!divcfg_ff[n] || meas) && !lp_off;
      end
    end
  end

  // Result FIFO; when full the oldest word is dropped and overrun flagged.
  always_ff @(posedge clk) begin
    if (push) begin
      fifo_mem[wp_ff] <= {channel_sel, core_data};
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wp_ff <= '0;
      rp_ff <= '0;
      level_ff <= '0;
    end else begin
      if (push) begin
        wp_ff <= ptr_inc(wp_ff);
      end
      if (pop || (push && full)) begin
        rp_ff <= ptr_inc(rp_ff);
      end
      if (push && !pop && !full) begin
        level_ff <= level_ff + 1'b1;
      end else if (pop && !push) begin
        level_ff <= level_ff - 1'b1;
      end
    end
  end

  // Sticky flags: a new event wins over a write-one clear in the same cycle.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      intfl_ff <= '0;
      ready_d_ff <= 1'b0;
      irq <= 1'b0;
    end else begin
      logic [SADC_INT_W-1:0] ev;
      logic [SADC_INT_W-1:0] nxt_fl;
      ev = '0;
      ev[SADC_INT_THR] = thr_ff != '0 && level_ff >= thr_ff;
      ev[SADC_INT_OVR] = push && full;
      ev[SADC_INT_DONE] = done_evt;
      ev[SADC_INT_RDY] = ready && !ready_d_ff;
      nxt_fl = intfl_ff;
      if (wr && addr == SADC_INTFL_OFS) begin
        nxt_fl = nxt_fl & ~wdata[SADC_INT_W-1:0];
      end
      nxt_fl = nxt_fl | ev;
      intfl_ff <= nxt_fl;
      ready_d_ff <= ready;
      irq <= |(nxt_fl & inten_ff);
    end
  end

  // Read data, valid the cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 32'h0;
    end else if (!rd) begin
      rdata <= 32'h0;
    end else if (addr >= SADC_CHSEL_OFS && addr <= SADC_CHSEL_END) begin
      rdata <= {3'h0, slot_chan[{addr[4:2], 2'h3}], 3'h0, slot_chan[{addr[4:2], 2'h2}],
                3'h0, slot_chan[{addr[4:2], 2'h1}], 3'h0, slot_chan[{addr[4:2], 2'h0}]};
    end else begin
      unique case (addr)
        SADC_CTRL_OFS: rdata <= ctrl_ff;
        SADC_CLK_OFS: rdata <= {25'h0, clkcfg_ff};
        SADC_SAMP_OFS: rdata <= {8'h0, idle_cnt_ff, 8'h0, track_cnt_ff};
        SADC_DELAY_OFS: rdata <= {16'h0, delay_ff};
        SADC_THR_OFS: rdata <= {27'h0, thr_ff};
        SADC_INTFL_OFS: rdata <= {28'h0, intfl_ff};
        SADC_INTEN_OFS: rdata <= {28'h0, inten_ff};
        SADC_FIFO_OFS: rdata <= {!empty, 10'h0, fifo_mem[rp_ff][16:12], 4'h0,
                                 fifo_mem[rp_ff][11:0]};
        SADC_STAT_OFS: rdata <= {19'h0, slot_ff, 1'b0, level_ff, ready, state_ff != ST_IDLE};
        SADC_DIVSEL_OFS: rdata <= {6'h0, divsel_ff};
        SADC_DIVCFG_OFS: rdata <= {14'h0, divcfg_ff};
        default: rdata <= 32'h0;
      endcase
    end
  end

  // Helper: conversion ticks seen while the sample clock is high.
  logic [15:0] hi_ticks_ff;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hi_ticks_ff <= 16'h0;
    end else if (!sample_clk) begin
      hi_ticks_ff <= 16'h0;
    end else if (conv_tick) begin
      hi_ticks_ff <= hi_ticks_ff + 16'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_hold_end;
    state_ff == ST_HOLD && push;
  endsequence
  sequence s_last_done;
    s_hold_end ##0 done_evt;
  endsequence

  property p_first_slot;
    state_ff == ST_ARMED && nxt_state == ST_TRACK |=> slot_ff == 5'h0;
  endproperty
  a_first_slot: assert property (p_first_slot) else $error("sequence not at slot 0");
  property p_single;
    s_last_done ##0 !cont && ready |=> state_ff == ST_IDLE;
  endproperty
  a_single: assert property (p_single) else $error("single sequence kept running");
  property p_repeat;
    s_last_done ##0 cont && ready && !wr |=> state_ff inside {ST_TRACK, ST_DELAY};
  endproperty
  a_repeat: assert property (p_repeat) else $error("continuous mode stopped");
  property p_ground;
    channel_sel <= SADC_GROUND_ID;
  endproperty
  a_ground: assert property (p_ground) else $error("reserved channel driven");
  property p_push_count;
    push && !pop && !full |=> level_ff == $past(level_ff) + 1'b1;
  endproperty
  a_push_count: assert property (p_push_count) else $error("result not stored");
  property p_track_len;
    $fell(sample_clk) && $past(state_ff) == ST_TRACK && state_ff == ST_HOLD
      |-> $past(hi_ticks_ff) + 16'h1 == track_len;
  endproperty
  a_track_len: assert property (p_track_len) else $error("track length wrong");
  property p_sample_hi;
    state_ff inside {ST_TRACK, ST_HOLD} |-> sample_clk == (state_ff == ST_TRACK);
  endproperty
  a_sample_hi: assert property (p_sample_hi) else $error("sample clock phase wrong");
  property p_trigger;
    state_ff == ST_ARMED && trig_hit_ff && conv_tick && ready && !wr |=> state_ff == ST_TRACK;
  endproperty
  a_trigger: assert property (p_trigger) else $error("trigger ignored");
  property p_irq;
    (intfl_ff & inten_ff) != '0 |-> ##[0:1] irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");
endmodule : sadc_seq

// File: tb/sadc_core_model.sv
// Behavioural converter core that answers the sequencer's sample clock.
`timescale 1ns/1ns
module sadc_core_model (
  input wire logic sample_clk,
  input wire logic [4:0] channel_sel,
  output logic [11:0] core_data
);
  // The result carries the channel so the bench can tell slots apart.
  logic [11:0] result;
  assign result = 12'hA00 | {7'h00, channel_sel};
  // While tracking the result is not ready, so the inverse is shown to catch early sampling.
  assign core_data = sample_clk ? ~result : result;
endmodule : sadc_core_model

// File: tb/sadc_seq_tb_top.sv
// Self-checking bench for the converter sequencer.
`timescale 1ns/1ns
module sadc_seq_tb_top;
  import sadc_pkg::*;
  logic clk = 1'b0; // System clock.
  logic rstn = 1'b0; // Reset, active low.
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [31:0] got; // Last value read.
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic timer_evt = 1'b0;
  logic lowpower_mode = 1'b0;
  logic trig_pin = 1'b0; // External trigger pin.
  logic [1:0] ext_div = 2'h0; // Free-running divider that makes the external clock pin.
  logic irq, sample_clk, core_resetn, core_bias_en, core_enable;
  logic [11:0] core_data;
  logic [4:0] channel_sel;
  logic [25:0] input_divider_select;
  logic [12:0] divider_enable;
  int fails = 0;
  int num_checks = 0;
  int hi, lo; // Measured phase lengths in clock cycles.
  // Clock of 50 ns period.
  always #25 clk = ~clk;
  // External clock pin at a quarter of the system clock, below the synchroniser limit.
  always @(posedge clk) ext_div <= ext_div + 2'h1;
  sadc_seq sadc_seq_inst (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .irq(irq), .ext_clk_pin(ext_div[1]), .baud_osc(1'b0),
    .fast_osc(1'b0), .timer_evt(timer_evt), .trig_pin(trig_pin),
    .lowpower_mode(lowpower_mode), .core_data(core_data), .sample_clk(sample_clk),
    .channel_sel(channel_sel), .core_resetn(core_resetn), .core_bias_en(core_bias_en),
    .core_enable(core_enable), .input_divider_select(input_divider_select),
    .divider_enable(divider_enable));
  sadc_core_model sadc_core_model_inst (.sample_clk(sample_clk),
    .channel_sel(channel_sel), .core_data(core_data));
  // Prints the verdict and ends the run.
  task automatic report_and_stop();
    if (fails == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop
  // Compares one value and reports a difference.
  task automatic chk(string what, logic [31:0] exp, logic [31:0] seen);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // One-cycle register write.
  task automatic wr_reg(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // One-cycle read; data is taken in the single cycle where it stands.
  task automatic rd_reg(logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 got = rdata;
  endtask : rd_reg
  // Waits for the sample clock to reach a level; a hang counts as a failure.
  task automatic wait_level(logic lvl, int bound);
    int i;
    #1;
    for (i = 0; i < bound && sample_clk !== lvl; i++) @(posedge clk) #1;
    if (i == bound) begin
      fails++;
      report_and_stop();
    end
  endtask : wait_level
  // Counts the cycles the sample clock stays at a level.
  task automatic count_level(logic lvl, output int n);
    n = 0;
    while (sample_clk === lvl && n < 400) begin
      @(posedge clk) #1;
      n++;
    end
    if (n == 400) begin
      fails++;
      report_and_stop();
    end
  endtask : count_level
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk("channel_sel", 32'h10, {27'h0, channel_sel});
    rd_reg(SADC_SAMP_OFS);
    chk("samp_reset", 32'h00000004, got);
    rd_reg(8'h3C);
    chk("unmapped", 32'h0, got);
    // Sleep, nap and on in turn.
    for (int m = 1; m < 8; m = m * 2 + 1) begin
      wr_reg(SADC_CTRL_OFS, 32'(m));
      repeat (2) @(posedge clk);
      #1 chk("power", 32'(m), {29'h0, core_enable, core_bias_en, core_resetn});
    end
    wr_reg(SADC_CHSEL_OFS, 32'h00001403);
    wr_reg(SADC_CLK_OFS, 32'h00000040);
    wr_reg(SADC_THR_OFS, 32'h2);
    wr_reg(SADC_INTEN_OFS, 32'h1);
    // Two slots, one conversion tick per clock.
    wr_reg(SADC_CTRL_OFS, 32'h0000010F);
    wait_level(1'b1, 20);
    count_level(1'b1, hi);
    chk("track", 32'd8, 32'(hi));
    count_level(1'b0, lo);
    chk("hold", 32'd17, 32'(lo));
    count_level(1'b1, hi);
    chk("track2", 32'd8, 32'(hi));
    repeat (20) @(posedge clk);
    #1 chk("irq_thr", 32'h1, {31'h0, irq});
    rd_reg(SADC_STAT_OFS);
    chk("status", 32'h0000000A, got);
    rd_reg(SADC_FIFO_OFS);
    chk("fifo0", 32'h80030A03, got);
    rd_reg(SADC_FIFO_OFS);
    chk("fifo1", 32'h80100A10, got);
    wr_reg(SADC_INTFL_OFS, 32'h1);
    repeat (3) @(posedge clk);
    #1 chk("irq_clr", 32'h0, {31'h0, irq});
    // Smallest and largest dividing settings.
    for (int d = 0; d < 4; d = d + 3) begin
      wr_reg(SADC_CLK_OFS, 32'(d << 4));
      wr_reg(SADC_CTRL_OFS, 32'h0000000F);
      wait_level(1'b1, 80);
      count_level(1'b1, hi);
      chk("div_track", 32'(8 << (d + 1)), 32'(hi));
      repeat (300) @(posedge clk);
    end
    // Continuous mode with a gap between repeats, then a stop.
    wr_reg(SADC_CLK_OFS, 32'h00000040);
    wr_reg(SADC_DELAY_OFS, 32'h5);
    wr_reg(SADC_CTRL_OFS, 32'h0000001F);
    wait_level(1'b1, 20);
    count_level(1'b1, hi);
    count_level(1'b0, lo);
    chk("gap", 32'd22, 32'(lo));
    wr_reg(SADC_CTRL_OFS, 32'h00000087);
    repeat (3) @(posedge clk);
    #1 chk("stopped", 32'h0, {31'h0, sample_clk});
    // A timer event starts the sequence only when it arrives.
    wr_reg(SADC_CTRL_OFS, 32'h0000002F);
    repeat (10) @(posedge clk);
    #1 chk("no_early", 32'h0, {31'h0, sample_clk});
    @(posedge clk);
    timer_evt <= 1'b1;
    @(posedge clk);
    timer_evt <= 1'b0;
    wait_level(1'b1, 20);
    // A rising edge on the trigger pin starts the next sequence.
    repeat (30) @(posedge clk);
    wr_reg(SADC_CTRL_OFS, 32'h0000004F);
    repeat (6) @(posedge clk);
    #1 chk("no_pin", 32'h0, {31'h0, sample_clk});
    @(posedge clk);
    trig_pin <= 1'b1;
    wait_level(1'b1, 20);
    // External clock pin as source: one tick every four system clocks.
    repeat (30) @(posedge clk);
    wr_reg(SADC_CLK_OFS, 32'h00000041);
    wr_reg(SADC_CTRL_OFS, 32'h0000000F);
    wait_level(1'b1, 80);
    count_level(1'b1, hi);
    chk("ext_track", 32'd32, 32'(hi));
    // Input dividers, their low-power switch-off and the dynamic enable.
    wr_reg(SADC_DIVSEL_OFS, 32'h9);
    wr_reg(SADC_DIVCFG_OFS, 32'h00010000);
    repeat (2) @(posedge clk);
    #1 chk("divsel", 32'h9, {28'h0, input_divider_select[3:0]});
    chk("div_on", 32'h3, {30'h0, divider_enable[1:0]});
    @(posedge clk);
    lowpower_mode <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("div_lp", 32'h2, {30'h0, divider_enable[1:0]});
    @(posedge clk);
    lowpower_mode <= 1'b0;
    wr_reg(SADC_DIVCFG_OFS, 32'h00000002);
    repeat (2) @(posedge clk);
    #1 chk("div_dyn", 32'h1, {30'h0, divider_enable[1:0]});
    report_and_stop();
  end
endmodule : sadc_seq_tb_top
